//--- src/tlb_tablewalk_demap.sv
// Translation buffer with hardware walk, partition tagging and demap.
// Assumes the pipeline presents at most one operation while op_ready_o is
// high, and a classic Wishbone master for the configuration registers.
//
// The register addresses and the Wishbone slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module tlb_tablewalk_demap #(
  parameter int ENTRIES = 64,
  parameter int IDX_W = 6
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Pipeline operation port
  input wire logic op_valid_i,
  input wire logic [2:0] op_code_i,
  input wire logic [tlb_pkg::VA_W-1:0] op_va_i,
  input wire logic [tlb_pkg::CTX_W-1:0] op_ctx_i,
  input wire logic op_real_i,
  input wire logic op_instr_i,
  input wire logic op_bypass_i,
  input wire logic [1:0] op_demap_i,
  input wire logic [IDX_W-1:0] op_index_i,
  input wire logic op_repl_i,
  input wire logic op_read_ram_i,
  input wire logic [63:0] op_tag_i,
  input wire logic [63:0] op_data_i,
  output logic op_ready_o,
  // Results
  output logic res_done_o,
  output logic res_hit_o,
  output logic [tlb_pkg::VA_W-1:0] res_pa_o,
  output logic [tlb_pkg::ATTR_W-1:0] res_attr_o,
  output logic [63:0] res_rdata_o,
  output logic [2:0] res_trap_o,
  // Level-2 read port for the walker
  output logic mem_req_o,
  output logic [tlb_pkg::VA_W-1:0] mem_addr_o,
  input wire logic mem_ack_i,
  input wire logic [63:0] mem_tag_i,
  input wire logic [63:0] mem_data_i
);

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers
  logic [31:0] ctrl_q;
  logic [31:0] part_reg_q;
  logic [31:0] sb_base_q [2];
  logic [31:0] sb_cfg_q [2];
  logic [31:0] ra_off_q;
  logic ack_q;
  logic [31:0] rdat_q;
  logic wb_req;
  logic [tlb_pkg::PART_W-1:0] part_q;
  logic walk_en;
  logic [31:0] status_w;

  assign wb_req = wb_cyc_i && wb_stb_i && !ack_q;
  assign part_q = part_reg_q[tlb_pkg::PART_W-1:0];
  assign walk_en = ctrl_q[tlb_pkg::CTRL_WALK_EN_BIT];

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) res[8*b +: 8] = nw[8*b +: 8];
    end
    return res;
  endfunction : merge

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= tlb_pkg::REG_RST;
      part_reg_q <= tlb_pkg::REG_RST;
      sb_base_q[0] <= tlb_pkg::REG_RST;
      sb_base_q[1] <= tlb_pkg::REG_RST;
      sb_cfg_q[0] <= tlb_pkg::REG_RST;
      sb_cfg_q[1] <= tlb_pkg::REG_RST;
      ra_off_q <= tlb_pkg::REG_RST;
    end else if (wb_req && wb_we_i) begin
      // Only the implemented field widths are kept
      unique case (wb_adr_i)
        tlb_pkg::REG_CTRL: ctrl_q <= merge(ctrl_q, wb_dat_i, wb_sel_i) & 32'h0000_0007;
        tlb_pkg::REG_PART: part_reg_q <= merge(part_reg_q, wb_dat_i, wb_sel_i) & 32'h0000_0007;
        tlb_pkg::REG_SB0_BASE: sb_base_q[0] <= merge(sb_base_q[0], wb_dat_i, wb_sel_i) & 32'h07ff_ffff;
        tlb_pkg::REG_SB0_CFG: sb_cfg_q[0] <= merge(sb_cfg_q[0], wb_dat_i, wb_sel_i) & 32'h0000_0077;
        tlb_pkg::REG_SB1_BASE: sb_base_q[1] <= merge(sb_base_q[1], wb_dat_i, wb_sel_i) & 32'h07ff_ffff;
        tlb_pkg::REG_SB1_CFG: sb_cfg_q[1] <= merge(sb_cfg_q[1], wb_dat_i, wb_sel_i) & 32'h0000_0077;
        tlb_pkg::REG_RA_OFFSET: ra_off_q <= merge(ra_off_q, wb_dat_i, wb_sel_i) & 32'h07ff_ffff;
        default: ;
      endcase
    end
  end

  // One-cycle acknowledge; unmapped offsets answer with zero data
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      rdat_q <= '0;
    end else begin
      ack_q <= wb_req;
      if (wb_req) begin
        unique case (wb_adr_i)
          tlb_pkg::REG_CTRL: rdat_q <= ctrl_q;
          tlb_pkg::REG_PART: rdat_q <= part_reg_q;
          tlb_pkg::REG_SB0_BASE: rdat_q <= sb_base_q[0];
          tlb_pkg::REG_SB0_CFG: rdat_q <= sb_cfg_q[0];
          tlb_pkg::REG_SB1_BASE: rdat_q <= sb_base_q[1];
          tlb_pkg::REG_SB1_CFG: rdat_q <= sb_cfg_q[1];
          tlb_pkg::REG_RA_OFFSET: rdat_q <= ra_off_q;
          tlb_pkg::REG_STATUS: rdat_q <= status_w;
          default: rdat_q <= '0;
        endcase
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  ////////////////////////////////////////////////////////////////////////////
  // Entry array and associative search
  tlb_pkg::entry_s tlb_q [ENTRIES];
  logic [tlb_pkg::PN_W-1:0] op_pn;
  logic [tlb_pkg::PN_W-1:0] m_c;
  logic own_c;
  logic pn_eq_c;
  logic look_hit;
  logic [IDX_W-1:0] look_idx;
  logic [ENTRIES-1:0] dm_vec;
  logic dm_page_taken;
  logic free_found;
  logic [IDX_W-1:0] free_idx;
  logic [IDX_W-1:0] rr_q;
  logic [IDX_W-1:0] repl_idx;

  assign op_pn = op_va_i[tlb_pkg::VA_W-1:tlb_pkg::PAGE_SHIFT];

  always_comb begin
    m_c = '0;
    own_c = 1'b0;
    pn_eq_c = 1'b0;
    look_hit = 1'b0;
    look_idx = '0;
    dm_vec = '0;
    dm_page_taken = 1'b0;
    free_found = 1'b0;
    free_idx = '0;
    for (int i = 0; i < ENTRIES; i++) begin
      m_c = tlb_pkg::page_mask(tlb_q[i].ps);
      pn_eq_c = ((tlb_q[i].vpage ^ op_pn) & m_c) == '0;
      own_c = tlb_q[i].valid && (tlb_q[i].part == part_q);
      if (!tlb_q[i].valid && !free_found) begin
        free_found = 1'b1;
        free_idx = i[IDX_W-1:0];
      end
      if (own_c && pn_eq_c && (tlb_q[i].rbit == op_real_i)
          && (tlb_q[i].rbit || (tlb_q[i].ctx == op_ctx_i)) && !look_hit) begin
        look_hit = 1'b1;
        look_idx = i[IDX_W-1:0];
      end
      if (own_c) begin
        unique case (tlb_pkg::demap_e'(op_demap_i))
          tlb_pkg::DM_PAGE: begin
            if (pn_eq_c && (tlb_q[i].rbit == op_real_i) && !dm_page_taken) begin
              dm_vec[i] = 1'b1;
              dm_page_taken = 1'b1;
            end
          end
          tlb_pkg::DM_CTX: dm_vec[i] = !tlb_q[i].rbit && (tlb_q[i].ctx == op_ctx_i);
          tlb_pkg::DM_ALL: dm_vec[i] = 1'b1;
          tlb_pkg::DM_ALL_PAGES: dm_vec[i] = (tlb_q[i].rbit == op_real_i);
        endcase
      end
    end
  end

  // Free slot first, otherwise round robin
  assign repl_idx = free_found ? free_idx : rr_q;

  ////////////////////////////////////////////////////////////////////////////
  // Operation acceptance
  walk_if wk ();
  logic busy_q;
  logic start_q;
  logic [tlb_pkg::VA_W-1:0] pend_va_q;
  logic [tlb_pkg::CTX_W-1:0] pend_ctx_q;
  logic pend_instr_q;
  logic take;
  tlb_pkg::op_e op;
  logic [IDX_W-1:0] wr_idx;

  // A walk in flight holds off every other operation
  assign op_ready_o = !busy_q;
  assign take = op_valid_i && !busy_q;
  assign op = tlb_pkg::op_e'(op_code_i);
  assign wr_idx = op_repl_i ? repl_idx : op_index_i;
  assign status_w = {25'h0, res_trap_o, 3'h0, busy_q};

  function automatic logic [tlb_pkg::VA_W-1:0] form_pa(input tlb_pkg::entry_s e,
                                                       input logic [tlb_pkg::VA_W-1:0] va);
    logic [tlb_pkg::PN_W-1:0] m;
    m = tlb_pkg::page_mask(e.ps);
    return {(e.ppage & m) | (va[tlb_pkg::VA_W-1:tlb_pkg::PAGE_SHIFT] & ~m),
            va[tlb_pkg::PAGE_SHIFT-1:0]};
  endfunction : form_pa

  ////////////////////////////////////////////////////////////////////////////
  // Entry array updates
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < ENTRIES; i++) begin
        tlb_q[i].valid <= 1'b0;
      end
      rr_q <= '0;
    end else if (wk.done && wk.hit) begin
      tlb_q[repl_idx] <= wk.entry;
      tlb_q[repl_idx].part <= part_q;
      if (!free_found) rr_q <= rr_q + 1'b1;
    end else if (take && op == tlb_pkg::OP_WRITE) begin
      // Both halves land in one cycle
      tlb_q[wr_idx].valid <= op_data_i[tlb_pkg::DATA_VALID_BIT];
      tlb_q[wr_idx].part <= part_q;
      tlb_q[wr_idx].rbit <= op_va_i[tlb_pkg::REAL_ADDR_BIT];
      tlb_q[wr_idx].ctx <= op_tag_i[tlb_pkg::TAG_CTX_LSB +: tlb_pkg::CTX_W];
      tlb_q[wr_idx].vpage <= op_tag_i[tlb_pkg::TAG_PN_LSB +: tlb_pkg::PN_W];
      tlb_q[wr_idx].ps <= op_data_i[tlb_pkg::DATA_PS_LSB +: tlb_pkg::PS_W];
      tlb_q[wr_idx].ppage <= op_data_i[tlb_pkg::DATA_PN_LSB +: tlb_pkg::PN_W];
      tlb_q[wr_idx].attr <= op_data_i[tlb_pkg::DATA_ATTR_LSB +: tlb_pkg::ATTR_W];
      if (op_repl_i && !free_found) rr_q <= rr_q + 1'b1;
    end else if (take && op == tlb_pkg::OP_DEMAP) begin
      // Only valid bits change; memory is never touched
      for (int i = 0; i < ENTRIES; i++) begin
        if (dm_vec[i]) tlb_q[i].valid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Translation, read and walk results
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      res_done_o <= 1'b0;
      res_hit_o <= 1'b0;
      res_pa_o <= '0;
      res_attr_o <= '0;
      res_rdata_o <= '0;
      res_trap_o <= tlb_pkg::TRAP_NONE;
      busy_q <= 1'b0;
      start_q <= 1'b0;
      pend_va_q <= '0;
      pend_ctx_q <= '0;
      pend_instr_q <= 1'b0;
    end else begin
      res_done_o <= 1'b0;
      start_q <= 1'b0;
      if (wk.done) begin
        busy_q <= 1'b0;
        res_done_o <= 1'b1;
        res_hit_o <= wk.hit;
        if (wk.hit) begin
          res_pa_o <= form_pa(wk.entry, pend_va_q);
          res_attr_o <= wk.entry.attr;
          res_trap_o <= tlb_pkg::TRAP_NONE;
        end else begin
          res_trap_o <= pend_instr_q ? tlb_pkg::TRAP_INSTR_WALK_MISS
                                     : tlb_pkg::TRAP_DATA_WALK_MISS;
        end
      end else if (take && op == tlb_pkg::OP_XLATE) begin
        if (op_bypass_i && op_instr_i) begin
          res_done_o <= 1'b1;
          res_hit_o <= 1'b1;
          res_pa_o <= op_va_i;
          res_attr_o <= '0;
          res_trap_o <= tlb_pkg::TRAP_NONE;
        end else if (look_hit) begin
          res_done_o <= 1'b1;
          res_hit_o <= 1'b1;
          res_pa_o <= form_pa(tlb_q[look_idx], op_va_i);
          res_attr_o <= tlb_q[look_idx].attr;
          res_trap_o <= tlb_pkg::TRAP_NONE;
        end else if (op_real_i) begin
          res_done_o <= 1'b1;
          res_hit_o <= 1'b0;
          res_trap_o <= op_instr_i ? tlb_pkg::TRAP_INSTR_REAL_MISS
                                   : tlb_pkg::TRAP_DATA_REAL_MISS;
        end else if (!walk_en) begin
          // Immediate trap to software handling
          res_done_o <= 1'b1;
          res_hit_o <= 1'b0;
          res_trap_o <= op_instr_i ? tlb_pkg::TRAP_INSTR_FAST_MISS
                                   : tlb_pkg::TRAP_DATA_FAST_MISS;
        end else begin
          busy_q <= 1'b1;
          start_q <= 1'b1;
          pend_va_q <= op_va_i;
          pend_ctx_q <= op_ctx_i;
          pend_instr_q <= op_instr_i;
        end
      end else if (take && op == tlb_pkg::OP_READ) begin
        res_done_o <= 1'b1;
        res_hit_o <= 1'b0;
        res_trap_o <= tlb_pkg::TRAP_NONE;
        if (op_read_ram_i) begin
          res_rdata_o <= {tlb_q[op_index_i].valid, 23'h0, tlb_q[op_index_i].ppage,
                          2'h0, tlb_q[op_index_i].attr, tlb_q[op_index_i].ps};
        end else begin
          res_rdata_o <= {tlb_q[op_index_i].valid, 2'h0, tlb_q[op_index_i].ctx,
                          1'b0, tlb_q[op_index_i].part, 3'h0, tlb_q[op_index_i].rbit,
                          13'h0, tlb_q[op_index_i].vpage};
        end
      end
    end
  end

  assign wk.req = start_q;
  assign wk.va = pend_va_q;
  assign wk.ctx = pend_ctx_q;

  ////////////////////////////////////////////////////////////////////////////
  // Walker
  logic [tlb_pkg::PN_W-1:0] base_w [2];
  logic [2:0] size_w [2];
  logic [tlb_pkg::PS_W-1:0] ps_w [2];

  always_comb begin
    for (int s = 0; s < 2; s++) begin
      base_w[s] = sb_base_q[s][tlb_pkg::PN_W-1:0];
      size_w[s] = sb_cfg_q[s][tlb_pkg::CFG_SIZE_LSB +: 3];
      ps_w[s] = sb_cfg_q[s][tlb_pkg::CFG_PS_LSB +: tlb_pkg::PS_W];
    end
  end

  table_walker walker_u (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wk(wk.walker),
    .sbuf_en_i({ctrl_q[tlb_pkg::CTRL_SB1_EN_BIT], ctrl_q[tlb_pkg::CTRL_SB0_EN_BIT]}),
    .sbuf_base_i(base_w),
    .sbuf_size_i(size_w),
    .sbuf_ps_i(ps_w),
    .ra_offset_i(ra_off_q[tlb_pkg::PN_W-1:0]),
    .mem_req_o(mem_req_o),
    .mem_addr_o(mem_addr_o),
    .mem_ack_i(mem_ack_i),
    .mem_tag_i(mem_tag_i),
    .mem_data_i(mem_data_i)
  );

endmodule : tlb_tablewalk_demap

`default_nettype wire

//--- src/tlb_pkg.sv
// Shared constants, types and helpers of the translation buffer block.
// Assumes a 40-bit physical space and 8 KiB base pages.
`default_nettype none

package tlb_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Address geometry
  localparam int VA_W = 40;
  localparam int PAGE_SHIFT = 13;
  localparam int PN_W = 27;
  localparam int CTX_W = 13;
  localparam int PART_W = 3;
  localparam int ATTR_W = 8;
  localparam int PS_W = 3;
  localparam int PS_SHIFT_STEP = 3;
  localparam int ENTRY_BYTES_LOG2 = 4;
  localparam logic [VA_W-1:0] SBUF_MIN_BYTES = 40'h00_0000_2000;
  localparam int REAL_ADDR_BIT = 10;

  ////////////////////////////////////////////////////////////////////////////
  // Memory entry words and read-back layout
  localparam int TAG_CTX_LSB = 48;
  localparam int TAG_PN_LSB = 0;
  localparam int DATA_VALID_BIT = 63;
  localparam int DATA_PN_LSB = 13;
  localparam int DATA_ATTR_LSB = 3;
  localparam int DATA_PS_LSB = 0;
  localparam int CAM_VALID_BIT = 63;
  localparam int CAM_PART_LSB = 44;
  localparam int CAM_RBIT_BIT = 40;

  ////////////////////////////////////////////////////////////////////////////
  // Register map (byte offsets) and fields
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_PART = 8'h04;
  localparam logic [7:0] REG_SB0_BASE = 8'h08;
  localparam logic [7:0] REG_SB0_CFG = 8'h0c;
  localparam logic [7:0] REG_SB1_BASE = 8'h10;
  localparam logic [7:0] REG_SB1_CFG = 8'h14;
  localparam logic [7:0] REG_RA_OFFSET = 8'h18;
  localparam logic [7:0] REG_STATUS = 8'h1c;
  localparam int CTRL_WALK_EN_BIT = 0;
  localparam int CTRL_SB0_EN_BIT = 1;
  localparam int CTRL_SB1_EN_BIT = 2;
  localparam int CFG_SIZE_LSB = 0;
  localparam int CFG_PS_LSB = 4;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_TRAP_LSB = 4;
  localparam logic [31:0] REG_RST = 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // Enumerations and entry type
  typedef enum logic [2:0] {
    OP_NOP = 3'b000,
    OP_XLATE = 3'b001,
    OP_DEMAP = 3'b010,
    OP_READ = 3'b011,
    OP_WRITE = 3'b100
  } op_e;

  typedef enum logic [1:0] {
    DM_PAGE = 2'b00,
    DM_CTX = 2'b01,
    DM_ALL = 2'b10,
    DM_ALL_PAGES = 2'b11
  } demap_e;

  typedef enum logic [2:0] {
    TRAP_NONE = 3'b000,
    TRAP_INSTR_FAST_MISS = 3'b001,
    TRAP_DATA_FAST_MISS = 3'b010,
    TRAP_INSTR_REAL_MISS = 3'b011,
    TRAP_DATA_REAL_MISS = 3'b100,
    TRAP_INSTR_WALK_MISS = 3'b101,
    TRAP_DATA_WALK_MISS = 3'b110
  } trap_e;

  typedef struct packed {
    logic valid;
    logic [PART_W-1:0] part;
    logic rbit;
    logic [CTX_W-1:0] ctx;
    logic [PN_W-1:0] vpage;
    logic [PS_W-1:0] ps;
    logic [PN_W-1:0] ppage;
    logic [ATTR_W-1:0] attr;
  } entry_s;

  // Page number bits that take part in a compare for a given page size
  function automatic logic [PN_W-1:0] page_mask(input logic [PS_W-1:0] ps);
    logic [PN_W-1:0] ones;
    ones = '1;
    return ones << (PS_SHIFT_STEP * ps);
  endfunction : page_mask

endpackage : tlb_pkg

`default_nettype wire

//--- src/walk_if.sv
// Request and answer between the lookup logic and the table walker.
// Assumes one clock shared by both ends.
`timescale 1ns/1ps
`default_nettype none

interface walk_if;
  logic req;
  logic [tlb_pkg::VA_W-1:0] va;
  logic [tlb_pkg::CTX_W-1:0] ctx;
  logic done;
  logic hit;
  tlb_pkg::entry_s entry;

  modport lookup (output req, output va, output ctx, input done, input hit, input entry);
  modport walker (input req, input va, input ctx, output done, output hit, output entry);
endinterface : walk_if

`default_nettype wire

//--- src/table_walker.sv
// Hardware walk of up to two in-memory translation storage buffers.
// Assumes a level-2 path that holds mem_req until it returns mem_ack.
`timescale 1ns/1ps
`default_nettype none

module table_walker (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Lookup side
  walk_if.walker wk,
  // Configuration
  input wire logic [1:0] sbuf_en_i,
  input wire logic [tlb_pkg::PN_W-1:0] sbuf_base_i [2],
  input wire logic [2:0] sbuf_size_i [2],
  input wire logic [tlb_pkg::PS_W-1:0] sbuf_ps_i [2],
  input wire logic [tlb_pkg::PN_W-1:0] ra_offset_i,
  // Level-2 read port
  output logic mem_req_o,
  output logic [tlb_pkg::VA_W-1:0] mem_addr_o,
  input wire logic mem_ack_i,
  input wire logic [63:0] mem_tag_i,
  input wire logic [63:0] mem_data_i
);

  typedef enum logic [1:0] {
    W_IDLE = 2'b00,
    W_FETCH = 2'b01,
    W_GAP = 2'b10
  } wstate_e;

  wstate_e state_q;
  logic sel_q;
  logic [tlb_pkg::VA_W-1:0] addr_q;
  logic done_q;
  logic hit_q;
  tlb_pkg::entry_s entry_q;
  logic [tlb_pkg::PN_W-1:0] req_pn;
  logic [tlb_pkg::PN_W-1:0] mem_pn;
  logic [tlb_pkg::PS_W-1:0] mem_ps;
  logic [tlb_pkg::PN_W-1:0] cmp_mask;
  logic match;

  assign req_pn = wk.va[tlb_pkg::VA_W-1:tlb_pkg::PAGE_SHIFT];
  assign mem_pn = mem_tag_i[tlb_pkg::TAG_PN_LSB +: tlb_pkg::PN_W];
  assign mem_ps = mem_data_i[tlb_pkg::DATA_PS_LSB +: tlb_pkg::PS_W];
  assign cmp_mask = tlb_pkg::page_mask(mem_ps);

  // Entry address: base's upper bits above the presumed page index
  function automatic logic [tlb_pkg::VA_W-1:0] entry_addr(input logic s);
    logic [tlb_pkg::VA_W-1:0] span;
    logic [tlb_pkg::VA_W-1:0] idx;
    span = (tlb_pkg::SBUF_MIN_BYTES << sbuf_size_i[s]) - 40'h1;
    idx = {13'h0, req_pn} >> (tlb_pkg::PS_SHIFT_STEP * sbuf_ps_i[s]);
    return ({sbuf_base_i[s], 13'h0} & ~span) | ((idx << tlb_pkg::ENTRY_BYTES_LOG2) & span);
  endfunction : entry_addr

  // Size, masked page number and context must all agree
  assign match = mem_data_i[tlb_pkg::DATA_VALID_BIT] && (mem_ps == sbuf_ps_i[sel_q])
      && (((mem_pn ^ req_pn) & cmp_mask) == '0)
      && (mem_tag_i[tlb_pkg::TAG_CTX_LSB +: tlb_pkg::CTX_W] == wk.ctx);

  ////////////////////////////////////////////////////////////////////////////
  // Walk sequence: each enabled buffer in order, first match wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= W_IDLE;
      sel_q <= 1'b0;
      addr_q <= '0;
      done_q <= 1'b0;
      hit_q <= 1'b0;
      entry_q <= '0;
    end else begin
      done_q <= 1'b0;
      unique case (state_q)
        W_IDLE: begin
          if (wk.req) begin
            if (sbuf_en_i[0]) begin
              sel_q <= 1'b0;
              addr_q <= entry_addr(1'b0);
              state_q <= W_FETCH;
            end else if (sbuf_en_i[1]) begin
              sel_q <= 1'b1;
              addr_q <= entry_addr(1'b1);
              state_q <= W_FETCH;
            end else begin
              done_q <= 1'b1;
              hit_q <= 1'b0;
            end
          end
        end
        W_FETCH: begin
          if (mem_ack_i) begin
            if (match) begin
              done_q <= 1'b1;
              hit_q <= 1'b1;
              entry_q.valid <= 1'b1;
              entry_q.part <= '0;
              entry_q.rbit <= 1'b0;
              entry_q.ctx <= wk.ctx;
              entry_q.vpage <= mem_pn;
              entry_q.ps <= mem_ps;
              // Real page becomes physical by the partition offset
              entry_q.ppage <= mem_data_i[tlb_pkg::DATA_PN_LSB +: tlb_pkg::PN_W] + ra_offset_i;
              entry_q.attr <= mem_data_i[tlb_pkg::DATA_ATTR_LSB +: tlb_pkg::ATTR_W];
              state_q <= W_IDLE;
            end else if (!sel_q && sbuf_en_i[1]) begin
              sel_q <= 1'b1;
              addr_q <= entry_addr(1'b1);
              state_q <= W_GAP;
            end else begin
              done_q <= 1'b1;
              hit_q <= 1'b0;
              state_q <= W_IDLE;
            end
          end
        end
        W_GAP: state_q <= W_FETCH;
        default: state_q <= W_IDLE;
      endcase
    end
  end

  // The gap state drops the request for a cycle between two reads
  assign mem_req_o = (state_q == W_FETCH);
  assign mem_addr_o = addr_q;
  assign wk.done = done_q;
  assign wk.hit = hit_q;
  assign wk.entry = entry_q;

endmodule : table_walker

`default_nettype wire

//--- tb/tlb_tablewalk_demap_assertions.sv
// Port checks of the translation buffer.
// Assumes binding onto the top module by name.
`timescale 1ns/1ps
`default_nettype none
module tlb_tablewalk_demap_assertions (
  // Clock and operations
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic op_valid_i,
  input wire logic [2:0] op_code_i,
  input wire logic op_ready_o,
  // Results and walker
  input wire logic res_done_o,
  input wire logic res_hit_o,
  input wire logic [2:0] res_trap_o,
  input wire logic mem_req_o,
  input wire logic mem_ack_i
);
  ////////////////////////////////////////
  wire take = op_valid_i && op_ready_o;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_read_answers: assert property (take && op_code_i == 3'h3 |=> res_done_o)
    else $error("read gave no result");
  a_demap_quiet: assert property (take && op_code_i == 3'h2 |=> !res_done_o)
    else $error("demap gave a result");
  a_write_quiet: assert property (take && op_code_i == 3'h4 |=> !res_done_o)
    else $error("write gave a result");
  a_xlate_answers: assert property (take && op_code_i == 3'h1 |=> res_done_o || !op_ready_o)
    else $error("translate neither answered nor walked");
  a_walk_busy: assert property (mem_req_o |-> !op_ready_o)
    else $error("operation accepted during walk");
  a_req_holds: assert property (mem_req_o && !mem_ack_i |=> mem_req_o)
    else $error("walk request dropped early");
  a_trap_misses: assert property (res_done_o && res_trap_o != 3'h0 |-> !res_hit_o)
    else $error("trap with hit");
  a_busy_ends: assert property (!op_ready_o |-> ##[1:200] op_ready_o)
    else $error("walk never finished");
endmodule : tlb_tablewalk_demap_assertions
bind tlb_tablewalk_demap tlb_tablewalk_demap_assertions u_chk (.*);
`default_nettype wire

//--- tb/l2_model.sv
// Level-2 responder for walker fetches; answers slowly with one fixed entry.
// Assumes the walker holds its request until acknowledged.
`timescale 1ns/1ps
`default_nettype none
module l2_model (
  // Clock and walker port
  input wire logic clk_i,
  input wire logic req_i,
  output logic ack_o,
  output logic [63:0] tag_o,
  output logic [63:0] data_o
);
  ////////////////////////////////////////
  logic [1:0] wait_q;
  logic [63:0] pat_q = 64'h5555_5555_5555_5555;
  // Idle words toggle so a stale word is never mistaken for an answer
  always_ff @(posedge clk_i) begin
    wait_q <= (req_i && !ack_o) ? wait_q + 2'h1 : 2'h0;
    ack_o <= req_i && !ack_o && wait_q == 2'h2;
    pat_q <= ~pat_q;
  end
  assign tag_o = ack_o ? 64'h0004_0000_0000_0010 : pat_q;
  assign data_o = ack_o ? 64'h8000_0000_0000_2000 : ~pat_q;
endmodule : l2_model
`default_nettype wire

//--- tb/tlb_tablewalk_demap_tb_top.sv
// Table-driven bench for the translation buffer.
// Assumes the bound checker and the level-2 model.
`timescale 1ns/1ps
`default_nettype none
module tlb_tablewalk_demap_tb_top;
  typedef struct packed {logic [39:0] va; logic [12:0] cx; logic [2:0] f; logic [3:0] ht;} row_s;
  localparam logic [39:0] VA0 = 40'h00_0002_001f;
  localparam logic [39:0] VA1 = 40'h00_0004_0005;
  row_s rows [5] = '{'{VA0, 13'h3, 3'h0, 4'h8}, '{VA0, 13'h4, 3'h0, 4'h2},
    '{VA0, 13'h4, 3'h2, 4'h1}, '{VA1, 13'h7, 3'h1, 4'h8}, '{VA0, 13'h3, 3'h3, 4'h3}};
  logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_we_i = 1'b0, op_valid_i = 1'b0;
  logic op_real_i = 1'b0, op_instr_i = 1'b0, op_bypass_i = 1'b0, wb_ack_o, op_ready_o;
  logic res_done_o, res_hit_o, mem_req_o, mem_ack_i, op_repl_i = 1'b0, op_read_ram_i = 1'b0;
  logic [1:0] op_demap_i = 2'h0;
  logic [2:0] op_code_i = 3'h0, res_trap_o;
  logic [5:0] op_index_i = 6'h0;
  logic [7:0] wb_adr_i = 8'h0, res_attr_o;
  logic [12:0] op_ctx_i = 13'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic [39:0] op_va_i = 40'h0, res_pa_o, mem_addr_o;
  logic [63:0] op_tag_i = 64'h0, op_data_i = 64'h0, res_rdata_o, mem_tag_i, mem_data_i;
  int bad_count = 0, cmp_count = 0;
  initial forever #12.5 clk_i = ~clk_i;
  tlb_tablewalk_demap u_dut (.*, .wb_stb_i(wb_cyc_i), .wb_sel_i(4'hf));
  l2_model u_mem (.clk_i(clk_i), .req_i(mem_req_o), .ack_o(mem_ack_i), .tag_o(mem_tag_i),
    .data_o(mem_data_i));
  ////////////////////////////////////////
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : summarize
  task automatic chk(input logic [63:0] s, input logic [63:0] e, input string n);
    cmp_count++;
    if (s !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // Bus cycle held until ack is sampled high; then released for a cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1 && ++n < 50);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    @(posedge clk_i);
    chk(n >= 50, 1'b0, "bus timeout");
    if (n >= 50) summarize();
  endtask : wb
  task automatic op(input logic [2:0] c, input logic [39:0] a, input logic [12:0] x,
    input logic [2:0] g);
    int n;
    n = 0;
    op_valid_i <= 1'b1;
    op_code_i <= c;
    op_va_i <= a;
    op_ctx_i <= x;
    {op_bypass_i, op_instr_i, op_real_i} <= g;
    do @(posedge clk_i); while (op_ready_o !== 1'b1 && ++n < 50);
    op_valid_i <= 1'b0;
    do @(posedge clk_i); while ((c == 3'h1 || c == 3'h3) && res_done_o !== 1'b1 && ++n < 50);
    chk(n >= 50, 1'b0, "operation timeout");
    if (n >= 50) summarize();
  endtask : op
  task automatic xl(input row_s r);
    op(3'h1, r.va, r.cx, r.f);
    chk({res_hit_o, res_trap_o}, r.ht, "hit and trap");
  endtask : xl
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    chk({op_ready_o, res_done_o, mem_req_o}, 3'h4, "idle outputs");
    wb(1'b1, tlb_pkg::REG_PART, 32'h5);
    wb(1'b0, 8'hfc, 32'h0);
    chk(rd, 32'h0, "unmapped read");
    op_tag_i <= 64'h0003_0000_0000_0010;
    op_data_i <= 64'h8000_0000_0024_62d0;
    op(3'h4, 40'h0, 13'h0, 3'h0);
    op_repl_i <= 1'b1;
    op_tag_i <= 64'h20;
    op_data_i <= 64'h8000_0000_008a_c000;
    op(3'h4, 40'h400, 13'h0, 3'h0);
    op_index_i <= 6'h1;
    op(3'h3, 40'h0, 13'h0, 3'h0);
    chk(res_rdata_o[46:40], 7'h51, "partition and real bit");
    op_read_ram_i <= 1'b1;
    op(3'h3, 40'h0, 13'h0, 3'h0);
    chk(res_rdata_o, 64'h8000_0000_008a_c000, "payload half");
    foreach (rows[i]) xl(rows[i]);
    xl(rows[0]);
    chk(res_pa_o, 40'h00_0024_601f, "translated address");
    chk(res_attr_o, 8'h5a, "page attributes");
    $display("table tests done");
    wb(1'b1, tlb_pkg::REG_PART, 32'h6);
    xl('{VA0, 13'h3, 3'h0, 4'h2});
    op_demap_i <= tlb_pkg::DM_ALL;
    op(3'h2, 40'h0, 13'h0, 3'h0);
    wb(1'b1, tlb_pkg::REG_PART, 32'h5);
    xl(rows[0]);
    op_demap_i <= tlb_pkg::DM_PAGE;
    op(3'h2, VA0, 13'h0, 3'h1);
    xl(rows[0]);
    op_demap_i <= tlb_pkg::DM_CTX;
    op(3'h2, VA0, 13'h3, 3'h0);
    xl('{VA0, 13'h3, 3'h0, 4'h2});
    xl(rows[3]);
    op_demap_i <= tlb_pkg::DM_ALL_PAGES;
    op(3'h2, 40'h0, 13'h0, 3'h1);
    xl('{VA1, 13'h7, 3'h1, 4'h4});
    $display("demap tests done");
    op(3'h1, 40'hab_cdef_0123, 13'h0, 3'h6);
    chk(res_pa_o, 40'hab_cdef_0123, "bypass address");
    wb(1'b1, tlb_pkg::REG_RA_OFFSET, 32'h2);
    wb(1'b1, tlb_pkg::REG_CTRL, 32'h3);
    xl('{VA0, 13'h4, 3'h0, 4'h8});
    chk(res_pa_o, 40'h00_0000_601f, "walked address");
    xl('{VA0, 13'h5, 3'h0, 4'h6});
    chk(mem_addr_o, 40'h00_0000_0100, "entry address");
    $display("walk test done");
    summarize();
  end
endmodule : tlb_tablewalk_demap_tb_top
`default_nettype wire
